// *** logic/dplcb_pkg.sv ***
// Purpose: shared constants, field layout and decode tables of the loop configuration bank
// Assumes: 32-bit serial words, register address in the low five bits of each word
// Notes:   ps, ohm, pF and uA outputs are plain binary values
package dplcb_pkg;

  // ==========================================================
  // widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned PS_W   = 16;
  localparam int unsigned CNT_W  = 14;
  localparam int unsigned DIV_W  = 10;

  // ==========================================================
  // register addresses (serial word bits 4:0)
  localparam logic [4:0] ADDR_FILTER_DELAY = 5'h18;
  localparam logic [4:0] ADDR_DAC_LOCK1    = 5'h19;
  localparam logic [4:0] ADDR_SECOND_LOOP  = 5'h1A;
  localparam logic [4:0] ADDR_FIRST_LOOP   = 5'h1B;
  localparam int unsigned ADDR_MSB = 4;

  // ==========================================================
  // field positions (lsb)
  localparam int unsigned CAP3_LSB      = 24;
  localparam int unsigned RES4_LSB      = 20;
  localparam int unsigned RES3_LSB      = 16;
  localparam int unsigned FB_DLY_LSB    = 12;
  localparam int unsigned REF_DLY_LSB   = 8;
  localparam int unsigned WIN1_LSB      = 6;
  localparam int unsigned DAC_DIV_LSB   = 22;
  localparam int unsigned LOCK_CNT_LSB  = 6;
  localparam int unsigned WIN2_LSB      = 30;
  localparam int unsigned DOUBLER_BIT   = 29;
  localparam int unsigned POL_BIT       = 28;
  localparam int unsigned GAIN_LSB      = 26;
  localparam int unsigned HIZ_BIT       = 5;
  localparam int unsigned PRE_ONE_LSB   = 22;
  localparam int unsigned PRE_ZERO_LSB  = 20;

  // ==========================================================
  // reset values
  localparam logic [WORD_W-1:0] RST_FILTER_DELAY = 32'h0000_0018;
  localparam logic [WORD_W-1:0] RST_DAC_LOCK1    = 32'h0040_0059;
  localparam logic [WORD_W-1:0] RST_SECOND_LOOP  = 32'h8000_005A;
  localparam logic [WORD_W-1:0] RST_FIRST_LOOP   = 32'h0000_001B;

  // ==========================================================
  // codes and steps
  localparam logic [3:0]  CAP3_RSV_FIRST = 4'hE;
  localparam logic [2:0]  RES_RSV_FIRST  = 3'h5;
  localparam logic [10:0] DLY_STEP_PS    = 11'h0CD;
  localparam logic [1:0]  WIN2_VALID     = 2'h2;
  localparam logic [PS_W-1:0] WIN2_PS    = 16'h0E74;

  typedef enum logic [1:0] {
    DPLCB_SER_IDLE  = 2'b00,
    DPLCB_SER_SHIFT = 2'b01,
    DPLCB_SER_LATCH = 2'b11
  } dplcb_ser_e;

  // ==========================================================
  // decode tables
  function automatic logic [5:0] dplcb_cap_pf(input logic [3:0] code);
    case (code)
      4'h0:    dplcb_cap_pf = 6'h0A;
      4'h1:    dplcb_cap_pf = 6'h0B;
      4'h2:    dplcb_cap_pf = 6'h0F;
      4'h3:    dplcb_cap_pf = 6'h10;
      4'h4:    dplcb_cap_pf = 6'h13;
      4'h5:    dplcb_cap_pf = 6'h14;
      4'h6:    dplcb_cap_pf = 6'h18;
      4'h7:    dplcb_cap_pf = 6'h19;
      4'h8:    dplcb_cap_pf = 6'h1D;
      4'h9:    dplcb_cap_pf = 6'h1E;
      4'hA:    dplcb_cap_pf = 6'h21;
      4'hB:    dplcb_cap_pf = 6'h22;
      4'hC:    dplcb_cap_pf = 6'h26;
      4'hD:    dplcb_cap_pf = 6'h27;
      default: dplcb_cap_pf = 6'h00;
    endcase
  endfunction

  function automatic logic [14:0] dplcb_res_ohm(input logic [2:0] code);
    case (code)
      3'h0:    dplcb_res_ohm = 15'h00C8;
      3'h1:    dplcb_res_ohm = 15'h03E8;
      3'h2:    dplcb_res_ohm = 15'h07D0;
      3'h3:    dplcb_res_ohm = 15'h0FA0;
      3'h4:    dplcb_res_ohm = 15'h3E80;
      default: dplcb_res_ohm = 15'h0000;
    endcase
  endfunction

  function automatic logic [PS_W-1:0] dplcb_win1_ps(input logic [1:0] code);
    case (code)
      2'h0:    dplcb_win1_ps = 16'h157C;
      2'h1:    dplcb_win1_ps = 16'h2710;
      2'h2:    dplcb_win1_ps = 16'h48A8;
      default: dplcb_win1_ps = 16'h9C40;
    endcase
  endfunction

  function automatic logic [11:0] dplcb_pump_ua(input logic second, input logic [1:0] code,
                                                input logic hiz);
    if (hiz) begin
      dplcb_pump_ua = 12'h000;
    end else begin
      case (code)
        2'h0:    dplcb_pump_ua = 12'h064;
        2'h1:    dplcb_pump_ua = second ? 12'h190 : 12'h0C8;
        2'h2:    dplcb_pump_ua = second ? 12'h640 : 12'h190;
        default: dplcb_pump_ua = second ? 12'hC80 : 12'h640;
      endcase
    end
  endfunction

  function automatic logic [10:0] dplcb_delay_ps(input logic [2:0] code, input logic zdm);
    dplcb_delay_ps = zdm ? 11'({8'h00, code} * DLY_STEP_PS) : 11'h000;
  endfunction

endpackage

// *** logic/dplcb_lock_if.sv ***
// Purpose: carries one loop's phase samples and lock settings to its lock detector
// Assumes: all signals on the bank clock
// Notes:   ctl side drives the samples, det side returns the lock level
`timescale 1ns/1ps
interface dplcb_lock_if;
  import dplcb_pkg::*;
  logic                strobe;
  logic [PS_W-1:0]     err_ps;
  logic [PS_W-1:0]     window_ps;
  logic [CNT_W-1:0]    target;
  logic                locked;

  modport det (input strobe, input err_ps, input window_ps, input target, output locked);
  modport ctl (output strobe, output err_ps, output window_ps, output target, input locked);
endinterface

// *** logic/dplcb_lock_det.sv ***
// Purpose: digital lock detect of one loop, one step per phase-detector strobe
// Assumes: strobe is one clock wide, error is the magnitude in ps
// Notes:   count code zero never locks
`timescale 1ns/1ps
module dplcb_lock_det
  import dplcb_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  arst_n,
  dplcb_lock_if.det  lk
);
  import dplcb_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             locked;
  } dplcb_lock_s;

  dplcb_lock_s lock_reg;
  dplcb_lock_s lock_next;
  logic        in_window;

  // ==========================================================
  // counter
  always_comb begin
    lock_next = lock_reg;
    in_window = lk.err_ps < lk.window_ps;
    if (lk.strobe) begin
      if (in_window) begin
        if (lock_reg.cnt != '1) begin
          lock_next.cnt = lock_reg.cnt + 14'h0001;
        end
        lock_next.locked = (lk.target != '0) && (lock_next.cnt >= lk.target); // R07 R10
      end else begin
        lock_next.cnt    = '0; // R19
        lock_next.locked = 1'b0; // R19
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= '0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  assign lk.locked = lock_reg.locked;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence miss_s;
    lk.strobe && (lk.err_ps >= lk.window_ps);
  endsequence

  lock_drop_a: assert property (miss_s |=> !lock_reg.locked && lock_reg.cnt == '0) // R19
    else $error("lock not cleared by out-of-window sample");
  lock_cause_a: assert property ($rose(lock_reg.locked) |-> $past(lk.strobe) && // R07
    $past(in_window) && lock_reg.cnt >= $past(lk.target) && $past(lk.target) != '0)
    else $error("lock rose without enough in-window samples");
  lock_early_a: assert property ($past(lk.strobe) && lock_reg.locked |-> lock_reg.cnt >= $past(lk.target)) // R10
    else $error("lock shown before count reached");
endmodule

// *** logic/dplcb_bank.sv ***
// Purpose: configuration bank of four words steering the second loop's filter, both loops' pumps and lock detect, and the dividers
// Assumes: serial port pins are asynchronous; phase samples come from logic on this clock
// Notes:   words are taken msb first, committed on the rising edge of the latch pin
//
// Functional notes
// [R01] third-pole capacitor from 4-bit code, 14-15 reserved
// [R02] fourth-pole resistor five values, codes 5-7 reserved
// [R03] third-pole resistor same five values encoding
// [R04] feedback delay code times 205 ps
// [R05] reference delay code times 205 ps
// [R06] first lock window 5.5/10/18.6/40 ns
// [R07] first lock after count in-window cycles
// [R08] DAC update clock divides first detector rate
// [R09] host keeps second window code at 2
// [R10] second lock after count in-window cycles
// [R11] doubler bit doubles second loop reference
// [R12] host avoids divide-by-one without doubler
// [R13] second pump polarity bit selects slope
// [R14] second pump current table, hiz overrides
// [R15] first pump polarity bit selects slope
// [R16] first pump current table, hiz overrides
// [R17] each input has 1/2/4/8 pre-divider
// [R18] active input switch applies its pre-divider
// [R19] out-of-window sample clears count and lock
`timescale 1ns/1ps
module dplcb_bank
  import dplcb_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 cfg_clk,
  input  wire logic                 cfg_data,
  input  wire logic                 cfg_latch,
  input  wire logic                 zero_delay_mode,
  input  wire logic                 active_input_sel,
  input  wire logic                 first_pd_strobe,
  input  wire logic [dplcb_pkg::PS_W-1:0] first_phase_err_ps,
  input  wire logic                 second_pd_strobe,
  input  wire logic [dplcb_pkg::PS_W-1:0] second_phase_err_ps,
  output logic      [5:0]           second_loop_third_pole_cap,
  output logic                      third_pole_cap_reserved,
  output logic      [14:0]          second_loop_fourth_pole_res,
  output logic      [14:0]          second_loop_third_pole_res,
  output logic      [1:0]           filter_res_reserved,
  output logic      [10:0]          feedback_path_delay,
  output logic      [10:0]          reference_path_delay,
  output logic      [11:0]          first_pump_current,
  output logic                      first_pump_hiz,
  output logic                      first_pump_polarity,
  output logic      [11:0]          second_pump_current,
  output logic                      second_pump_hiz,
  output logic                      second_pump_polarity,
  output logic                      reference_doubler_enable,
  output logic      [3:0]           active_predivide,
  output logic                      dac_update,
  output logic                      first_locked,
  output logic                      second_locked
);
  import dplcb_pkg::*;

  typedef struct packed {
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic [2:0]        s3;
    logic [2:0]        pin;
    logic [WORD_W-1:0] sh;
    dplcb_ser_e        st;
    logic [WORD_W-1:0] filt;
    logic [WORD_W-1:0] dacw;
    logic [WORD_W-1:0] sec;
    logic [WORD_W-1:0] fst;
    logic [5:0]        cap;
    logic              cap_rsv;
    logic [14:0]       r4;
    logic [14:0]       r3;
    logic [1:0]        res_rsv;
    logic [10:0]       fb_dly;
    logic [10:0]       ref_dly;
    logic [11:0]       p1_ua;
    logic              p1_hiz;
    logic              p1_pol;
    logic [11:0]       p2_ua;
    logic              p2_hiz;
    logic              p2_pol;
    logic              dbl;
    logic [3:0]        pre;
    logic [DIV_W-1:0]  dac_cnt;
    logic              dac_upd;
    logic [PS_W-1:0]   win1;
    logic [PS_W-1:0]   win2;
  } dplcb_bank_s;

  dplcb_bank_s bank_reg;
  dplcb_bank_s bank_next;
  logic [2:0]  rise;
  logic [DIV_W-1:0] dac_div;
  logic [1:0]  pre_code;

  dplcb_lock_if lock_one ();
  dplcb_lock_if lock_two ();

  // ==========================================================
  // serial port: three-stage pin sampling, shift, commit
  always_comb begin
    bank_next    = bank_reg;
    bank_next.s1 = {cfg_latch, cfg_data, cfg_clk};
    bank_next.s2 = bank_reg.s1;
    bank_next.s3 = bank_reg.s2;
    rise         = 3'h0;
    // a pin level counts once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      if (bank_reg.s2[i] == bank_reg.s3[i]) begin
        bank_next.pin[i] = bank_reg.s3[i];
        rise[i]          = bank_reg.s3[i] && !bank_reg.pin[i];
      end
    end
    case (bank_reg.st)
      DPLCB_SER_IDLE: begin
        // latch edges seen here commit nothing
        if (rise[0] && !bank_next.pin[2]) begin
          bank_next.sh = {bank_reg.sh[WORD_W-2:0], bank_next.pin[1]};
          bank_next.st = DPLCB_SER_SHIFT;
        end
      end
      DPLCB_SER_SHIFT: begin
        if (rise[2]) begin
          bank_next.st = DPLCB_SER_LATCH;
        end else if (rise[0]) begin
          bank_next.sh = {bank_reg.sh[WORD_W-2:0], bank_next.pin[1]};
        end
      end
      DPLCB_SER_LATCH: begin
        case (bank_reg.sh[ADDR_MSB:0])
          ADDR_FILTER_DELAY: bank_next.filt = bank_reg.sh;
          ADDR_DAC_LOCK1:    bank_next.dacw = bank_reg.sh;
          ADDR_SECOND_LOOP:  bank_next.sec  = bank_reg.sh;
          ADDR_FIRST_LOOP:   bank_next.fst  = bank_reg.sh;
          default:           bank_next.filt = bank_reg.filt;
        endcase
        bank_next.st = DPLCB_SER_IDLE;
      end
      default: bank_next.st = DPLCB_SER_IDLE;
    endcase

    // ==========================================================
    // decoded controls
    // reserved codes read as zero and raise their flag
    bank_next.cap     = dplcb_cap_pf(bank_reg.filt[CAP3_LSB+:4]); // R01
    bank_next.cap_rsv = bank_reg.filt[CAP3_LSB+:4] >= CAP3_RSV_FIRST; // R01
    bank_next.r4      = dplcb_res_ohm(bank_reg.filt[RES4_LSB+:3]); // R02
    bank_next.r3      = dplcb_res_ohm(bank_reg.filt[RES3_LSB+:3]); // R03
    bank_next.res_rsv = {bank_reg.filt[RES4_LSB+:3] >= RES_RSV_FIRST,
                         bank_reg.filt[RES3_LSB+:3] >= RES_RSV_FIRST};
    bank_next.fb_dly  = dplcb_delay_ps(bank_reg.filt[FB_DLY_LSB+:3], zero_delay_mode); // R04
    bank_next.ref_dly = dplcb_delay_ps(bank_reg.filt[REF_DLY_LSB+:3], zero_delay_mode); // R05
    bank_next.win1    = dplcb_win1_ps(bank_reg.filt[WIN1_LSB+:2]); // R06
    bank_next.win2    = WIN2_PS; // R09
    bank_next.p2_hiz  = bank_reg.sec[HIZ_BIT];
    bank_next.p2_ua   = dplcb_pump_ua(1'b1, bank_reg.sec[GAIN_LSB+:2], bank_reg.sec[HIZ_BIT]); // R14
    bank_next.p2_pol  = bank_reg.sec[POL_BIT]; // R13
    bank_next.dbl     = bank_reg.sec[DOUBLER_BIT]; // R11
    bank_next.p1_hiz  = bank_reg.fst[HIZ_BIT];
    bank_next.p1_ua   = dplcb_pump_ua(1'b0, bank_reg.fst[GAIN_LSB+:2], bank_reg.fst[HIZ_BIT]); // R16
    bank_next.p1_pol  = bank_reg.fst[POL_BIT]; // R15
    pre_code          = active_input_sel ? bank_reg.fst[PRE_ONE_LSB+:2]
                                         : bank_reg.fst[PRE_ZERO_LSB+:2]; // R18
    bank_next.pre     = 4'(4'h1 << pre_code); // R17

    // ==========================================================
    // DAC update divider on first loop detector strobes
    dac_div           = bank_reg.dacw[DAC_DIV_LSB+:DIV_W];
    bank_next.dac_upd = 1'b0;
    if (first_pd_strobe && dac_div != '0) begin
      if (bank_reg.dac_cnt >= dac_div - 10'h001) begin
        bank_next.dac_cnt = '0; // R08
        bank_next.dac_upd = 1'b1;
      end else begin
        bank_next.dac_cnt = bank_reg.dac_cnt + 10'h001;
      end
    // divisor code zero parks the count, no pulses
    end else if (dac_div == '0) begin
      bank_next.dac_cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_reg      <= '0;
      bank_reg.st   <= DPLCB_SER_IDLE;
      bank_reg.filt <= RST_FILTER_DELAY;
      bank_reg.dacw <= RST_DAC_LOCK1;
      bank_reg.sec  <= RST_SECOND_LOOP;
      bank_reg.fst  <= RST_FIRST_LOOP;
    end else begin
      bank_reg <= bank_next;
    end
  end

  // ==========================================================
  // lock detectors
  assign lock_one.strobe    = first_pd_strobe;
  assign lock_one.err_ps    = first_phase_err_ps;
  assign lock_one.window_ps = bank_reg.win1; // R06
  assign lock_one.target    = bank_reg.dacw[LOCK_CNT_LSB+:CNT_W]; // R07
  assign lock_two.strobe    = second_pd_strobe;
  assign lock_two.err_ps    = second_phase_err_ps;
  assign lock_two.window_ps = bank_reg.win2;
  assign lock_two.target    = bank_reg.sec[LOCK_CNT_LSB+:CNT_W]; // R10

  dplcb_lock_det u_lock_one (
    .clock  (clock),
    .arst_n (arst_n),
    .lk     (lock_one.det)
  );

  dplcb_lock_det u_lock_two (
    .clock  (clock),
    .arst_n (arst_n),
    .lk     (lock_two.det)
  );

  // ==========================================================
  // outputs
  assign second_loop_third_pole_cap  = bank_reg.cap;
  assign third_pole_cap_reserved     = bank_reg.cap_rsv;
  assign second_loop_fourth_pole_res = bank_reg.r4;
  assign second_loop_third_pole_res  = bank_reg.r3;
  assign filter_res_reserved         = bank_reg.res_rsv;
  assign feedback_path_delay         = bank_reg.fb_dly;
  assign reference_path_delay        = bank_reg.ref_dly;
  assign first_pump_current          = bank_reg.p1_ua;
  assign first_pump_hiz              = bank_reg.p1_hiz;
  assign first_pump_polarity         = bank_reg.p1_pol;
  assign second_pump_current         = bank_reg.p2_ua;
  assign second_pump_hiz             = bank_reg.p2_hiz;
  assign second_pump_polarity        = bank_reg.p2_pol;
  assign reference_doubler_enable    = bank_reg.dbl;
  assign active_predivide            = bank_reg.pre;
  assign dac_update                  = bank_reg.dac_upd;
  assign first_locked                = lock_one.locked;
  assign second_locked               = lock_two.locked;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence commit_filter_s;
    bank_reg.st == DPLCB_SER_LATCH && bank_reg.sh[ADDR_MSB:0] == ADDR_FILTER_DELAY;
  endsequence

  sequence commit_second_s;
    bank_reg.st == DPLCB_SER_LATCH && bank_reg.sh[ADDR_MSB:0] == ADDR_SECOND_LOOP;
  endsequence

  word_commit_a: assert property (commit_filter_s |=> bank_reg.filt == $past(bank_reg.sh))
    else $error("filter word not committed");
  cap_select_a: assert property (commit_filter_s ##1 1'b1 |=>
    second_loop_third_pole_cap == dplcb_cap_pf($past(bank_reg.sh[CAP3_LSB+:4], 2))) // R01
    else $error("capacitor code not applied");
  res_select_a: assert property (commit_filter_s |-> ##2
    (second_loop_fourth_pole_res == dplcb_res_ohm($past(bank_reg.sh[RES4_LSB+:3], 2)) &&
     second_loop_third_pole_res == dplcb_res_ohm($past(bank_reg.sh[RES3_LSB+:3], 2)))) // R02 R03
    else $error("resistor codes not applied");
  delay_step_a: assert property ($past(zero_delay_mode) |->
    feedback_path_delay == 11'($past(bank_reg.filt[FB_DLY_LSB+:3]) * DLY_STEP_PS) &&
    reference_path_delay == 11'($past(bank_reg.filt[REF_DLY_LSB+:3]) * DLY_STEP_PS)) // R04 R05
    else $error("path delay wrong");
  delay_off_a: assert property (!$past(zero_delay_mode) |-> feedback_path_delay == '0) // R04
    else $error("delay outside zero-delay mode");
  doubler_bit_a: assert property (commit_second_s |-> ##2
    reference_doubler_enable == $past(bank_reg.sh[DOUBLER_BIT], 2) &&
    second_pump_polarity == $past(bank_reg.sh[POL_BIT], 2)) // R11 R13
    else $error("doubler or polarity not applied");
  pump_hiz_a: assert property ((second_pump_hiz |-> second_pump_current == '0) and
    (first_pump_hiz |-> first_pump_current == '0)) // R14 R16
    else $error("pump current while high impedance");
  pump_max_a: assert property (first_pump_current <= 12'h640 && second_pump_current <= 12'hC80) // R16
    else $error("pump current beyond table");
  pre_switch_a: assert property ($changed(active_input_sel) |=>
    active_predivide == 4'(4'h1 << ($past(active_input_sel) ? bank_reg.fst[PRE_ONE_LSB+:2]
                                                         : bank_reg.fst[PRE_ZERO_LSB+:2]))) // R17 R18
    else $error("pre-divider of new input not applied");
  dac_rate_a: assert property (dac_update |-> $past(first_pd_strobe) && bank_reg.dac_cnt == '0 &&
    $past(bank_reg.dac_cnt) == $past(dac_div) - 10'h001) // R08
    else $error("DAC update off its divisor");
  dac_zero_a: assert property (dac_div == '0 |=> !dac_update) // R08
    else $error("DAC update with reserved divisor");
  ref_off_a: assert property (!$past(zero_delay_mode) |-> reference_path_delay == '0) // R05
    else $error("reference delay outside zero-delay mode");
  cap_blank_a: assert property (third_pole_cap_reserved |-> second_loop_third_pole_cap == '0) // R01
    else $error("reserved capacitor code not blanked");
  res4_blank_a: assert property (filter_res_reserved[1] |-> second_loop_fourth_pole_res == '0) // R02
    else $error("reserved fourth-pole resistor code not blanked");
  res3_blank_a: assert property (filter_res_reserved[0] |-> second_loop_third_pole_res == '0) // R03
    else $error("reserved third-pole resistor code not blanked");
  pre_ratio_a: assert property ($past(arst_n) |-> $onehot(active_predivide)) // R17
    else $error("pre-divider ratio not one of 1, 2, 4, 8");
  latch_start_a: assert property (bank_reg.st == DPLCB_SER_SHIFT && rise[2] |=> bank_reg.st == DPLCB_SER_LATCH)
    else $error("latch edge did not start a commit");
  idle_hold_a: assert property (bank_reg.st == DPLCB_SER_IDLE && !rise[0] |=> $stable(bank_reg.sh))
    else $error("shift register moved without a serial clock edge");
endmodule

// *** verif/dplcb_host_model.sv ***
// Purpose: host side of the serial configuration port
// Assumes: pins change at falling clock edge, at least four clocks per level
// Notes:   serial clock stands still low between frames
`timescale 1ns/1ps
module dplcb_host_model
  import dplcb_pkg::*;
#(
  parameter logic INTERNAL_OSC = 1'b0
) (
  input  wire logic clock,
  output logic      cfg_clk,
  output logic      cfg_data,
  output logic      cfg_latch
);
  import dplcb_pkg::*;
  initial begin
    cfg_clk   = 1'b0;
    cfg_data  = 1'b0;
    cfg_latch = 1'b0;
  end
  // ==========================================================
  // one word, msb first, then latch
  task automatic send_word(input logic [WORD_W-1:0] word);
    logic [WORD_W-1:0] w;
    w = word;
    if (w[ADDR_MSB:0] == ADDR_SECOND_LOOP) begin
      w[WIN2_LSB+:2] = WIN2_VALID;
      // second reference divider lives outside this bank
      if (INTERNAL_OSC) begin
        w[POL_BIT] = 1'b0;
      end
    end
    for (int i = WORD_W - 1; i >= 0; i--) begin
      @(negedge clock);
      cfg_data = w[i];
      repeat (4) @(negedge clock);
      cfg_clk = 1'b1;
      repeat (4) @(negedge clock);
      cfg_clk = 1'b0;
    end
    repeat (4) @(negedge clock);
    cfg_latch = 1'b1;
    cfg_data  = ~w[0];
    repeat (10) @(negedge clock);
    cfg_latch = 1'b0;
    repeat (4) @(negedge clock);
  endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the loop configuration bank
// Assumes: host model writes words, bench drives phase samples
// Notes:   inputs change at falling clock edge
`timescale 1ns/1ps
module tb_top;
  import dplcb_pkg::*;
  logic            clock, arst_n, zero_delay_mode, active_input_sel;
  logic            first_pd_strobe, second_pd_strobe, cfg_clk, cfg_data, cfg_latch;
  logic [PS_W-1:0] first_phase_err_ps, second_phase_err_ps;
  logic [5:0]      second_loop_third_pole_cap;
  logic [14:0]     second_loop_fourth_pole_res, second_loop_third_pole_res;
  logic [10:0]     feedback_path_delay, reference_path_delay;
  logic [11:0]     first_pump_current, second_pump_current;
  logic [3:0]      active_predivide;
  logic [1:0]      filter_res_reserved;
  logic            third_pole_cap_reserved, first_pump_hiz, first_pump_polarity, second_pump_hiz;
  logic            second_pump_polarity, reference_doubler_enable, dac_update, first_locked, second_locked;
  int              err_count, n_compared, pulses;

  dplcb_bank dplcb_bank_i (.*);
  dplcb_host_model dplcb_host_model_i (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (dac_update === 1'b1) pulses <= pulses + 1;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    dplcb_host_model_i.send_word(w);
  endtask
  task automatic strobe(input logic sec, input logic [15:0] e);
    first_pd_strobe = !sec;
    second_pd_strobe = sec;
    first_phase_err_ps = e;
    second_phase_err_ps = e;
    @(negedge clock);
    first_pd_strobe = 1'b0;
    second_pd_strobe = 1'b0;
    @(negedge clock);
  endtask
  task automatic wait2();
    repeat (2) @(negedge clock);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("cap", 16'h000A, 16'(second_loop_third_pole_cap));
    chk("res4", 16'h00C8, 16'(second_loop_fourth_pole_res));
    chk("res3", 16'h00C8, 16'(second_loop_third_pole_res));
    chk("pump1", 16'h0064, 16'(first_pump_current));
    chk("pump2", 16'h0064, 16'(second_pump_current));
  endtask
  task automatic t_filter();
    zero_delay_mode = 1'b1;
    wr(32'h0D41_7318);
    chk("cap", 16'h0027, 16'(second_loop_third_pole_cap));
    chk("res4", 16'h3E80, 16'(second_loop_fourth_pole_res));
    chk("res3", 16'h03E8, 16'(second_loop_third_pole_res));
    chk("fbdly", 16'h059B, 16'(feedback_path_delay));
    wr(32'hFFFF_FFFC);
    chk("refdly", 16'h0267, 16'(reference_path_delay));
    wr(32'h0E57_1018);
    chk("rsv", 16'h0007, 16'({third_pole_cap_reserved, filter_res_reserved}));
    chk("cap", 16'h0000, 16'(second_loop_third_pole_cap));
    chk("fbdly", 16'h00CD, 16'(feedback_path_delay));
    zero_delay_mode = 1'b0;
    wait2();
    chk("fbdly", 16'h0000, 16'(feedback_path_delay));
    chk("refdly", 16'h0000, 16'(reference_path_delay));
  endtask
  task automatic t_pumps();
    logic [11:0] one [4];
    logic [11:0] two [4];
    one = '{12'h064, 12'h0C8, 12'h190, 12'h640};
    two = '{12'h064, 12'h190, 12'h640, 12'hC80};
    for (int g = 0; g < 4; g++) begin
      wr({2'h2, g[1], g[0], 2'(g), 6'h00, 14'h0001, 1'b0, ADDR_SECOND_LOOP});
      wr({3'h0, g[0], 2'(g), 2'h0, 2'(g), 2'(3 - g), 14'h0001, 1'b0, ADDR_FIRST_LOOP});
      chk("pump1", 16'(one[g]), 16'(first_pump_current));
      chk("pump2", 16'(two[g]), 16'(second_pump_current));
      chk("pol1", 16'(g[0]), 16'(first_pump_polarity));
      chk("pol2", 16'(g[0]), 16'(second_pump_polarity));
      chk("dbl", 16'(g[1]), 16'(reference_doubler_enable));
      active_input_sel = 1'b0;
      wait2();
      chk("prediv0", 16'(1 << (3 - g)), 16'(active_predivide));
      active_input_sel = 1'b1;
      wait2();
      chk("prediv1", 16'(1 << g), 16'(active_predivide));
    end
    wr({2'h2, 4'h0, 6'h00, 14'h0001, 1'b1, ADDR_SECOND_LOOP});
    wr({3'h0, 1'b0, 2'h3, 6'h00, 14'h0001, 1'b1, ADDR_FIRST_LOOP});
    chk("hiz", 16'h0003, 16'({first_pump_hiz, second_pump_hiz}));
    chk("pumps", 16'h0000, 16'(first_pump_current | second_pump_current));
  endtask
  task automatic t_lock1();
    wr({10'h002, 2'h0, 14'h0003, 1'b0, ADDR_DAC_LOCK1});
    strobe(0, 16'h157B);
    strobe(0, 16'h0000);
    chk("lock1", 16'h0000, 16'(first_locked));
    strobe(0, 16'h1000);
    chk("lock1", 16'h0001, 16'(first_locked));
    strobe(0, 16'h157C);
    chk("lock1", 16'h0000, 16'(first_locked));
    wr(32'h0D41_73D8);
    repeat (3) strobe(0, 16'h9C3F);
    chk("lock1", 16'h0001, 16'(first_locked));
    strobe(0, 16'h9C40);
    chk("lock1", 16'h0000, 16'(first_locked));
    pulses = 0;
    repeat (6) strobe(0, 16'h0000);
    chk("dac", 16'h0003, 16'(pulses));
  endtask
  task automatic t_lock2();
    wr({2'h2, 4'h0, 6'h00, 14'h0002, 1'b0, ADDR_SECOND_LOOP});
    strobe(1, 16'h0E73);
    chk("lock2", 16'h0000, 16'(second_locked));
    strobe(1, 16'h0E73);
    chk("lock2", 16'h0001, 16'(second_locked));
    strobe(1, 16'h0E74);
    chk("lock2", 16'h0000, 16'(second_locked));
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {arst_n, zero_delay_mode, active_input_sel, first_pd_strobe, second_pd_strobe} = '0;
    first_phase_err_ps = '0;
    second_phase_err_ps = '0;
    err_count = 0;
    n_compared = 0;
    pulses = 0;
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    wait2();
    t_reset();
    t_filter();
    t_pumps();
    t_lock1();
    t_lock2();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule
